// [rtl/subsystem_gpio_control.sv]
`timescale 1ns/1ns
module subsystem_gpio_control
  import gpio_ctrl_pkg::*;
(
  input  wire logic                  CLOCK_I,
  input  wire logic                  RSTN_I,
  input  wire logic [ADDR_W-1:0]     ADDR_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  input  wire logic [DATA_W-1:0]     WDATA_I,
  output logic      [DATA_W-1:0]     RDATA_O,
  input  wire logic [PIN_N-1:0]      PIN_I,
  output logic      [PIN_N-1:0]      PIN_O,
  output logic      [PIN_N-1:0]      PIN_OE_O,
  input  wire gpio_ctrl_pkg::route_src_s ROUTE_I,
  output logic                       BRANCH_CONTROL_INPUT_O,
  input  wire logic [3:0]            SUBSYS_CLK_I,
  output logic                       CLOCK_OUT_O
);
  import gpio_ctrl_pkg::*;

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [PIN_N-1:0]  pin_sync;
  logic [PIN_N-1:0]  pin_direction;
  logic [PIN_N-1:0]  pin_value;
  logic [1:0]        clock_out_select;
  logic              timer_pin_route;
  logic              branch_input_route;
  logic              flag_output_route;
  logic              watchdog_pin_route;
  logic              reg_hit;
  pin_drive_s        drive_d;
  pin_drive_s        drive_q;
  clk_sel_e          clk_sel_d;
  clk_sel_e          clk_sel_q;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] rdata_q;
  logic              rd_hit;
  logic [PIN_N-1:0]  force_out;
  logic [PIN_N-1:0]  force_in;
  logic [PIN_N-1:0]  force_value;
  wire  [PIN_N-1:0]  pin_oe_d;
  wire  [PIN_N-1:0]  pin_value_d;
  wire  [PIN_N-1:0]  pin_read;
  logic              branch_d;
  logic              branch_q;
  logic [3:0]        clk_pick;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  pin_sync #(
    .WIDTH (PIN_N)
  ) u_pin_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RSTN_I),
    .async_i (PIN_I),
    .sync_o  (pin_sync)
  );

  // ****************************************************************
  // register fields
  // ****************************************************************
  assign reg_hit            = (ADDR_I == PIN_CONTROL_ADDR); // R11
  assign pin_direction      = ctrl_q[DIR_LSB +: PIN_N];
  assign pin_value          = ctrl_q[VALUE_LSB +: PIN_N];
  assign clock_out_select   = ctrl_q[CLKSEL_LSB +: 2];
  assign timer_pin_route    = ctrl_q[TIMER_ROUTE_BIT];
  assign branch_input_route = ctrl_q[BRANCH_ROUTE_BIT];
  assign flag_output_route  = ctrl_q[FLAG_ROUTE_BIT];
  assign watchdog_pin_route = ROUTE_I.watchdog_route;

  // ****************************************************************
  // control register
  // ****************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (WR_I && reg_hit) begin
      ctrl_d = WDATA_I & PIN_CONTROL_WMSK; // R7 R11
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ctrl_q <= PIN_CONTROL_RST; // R8
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************************************
  // pin routes
  // ****************************************************************
  // a route takes its pin over whatever the direction bit says
  always_comb begin
    force_out   = '0;
    force_in    = '0;
    force_value = '0;
    if (timer_pin_route) begin
      force_out[TIMER_PIN]   = 1'b1; // R3
      force_value[TIMER_PIN] = ROUTE_I.timer_out;
    end
    if (watchdog_pin_route) begin
      force_out[WATCHDOG_PIN]   = 1'b1; // R10
      force_value[WATCHDOG_PIN] = ROUTE_I.watchdog_out;
    end
    // the branch route keeps its pin released so the board can drive it
    if (branch_input_route) begin
      force_in[BRANCH_PIN] = 1'b1; // R4
    end
    if (flag_output_route) begin
      force_out[FLAG_PIN]   = 1'b1; // R5
      force_value[FLAG_PIN] = ROUTE_I.flag_out;
    end
  end

  // ****************************************************************
  // per-pin enable and value
  // ****************************************************************
  for (genvar n = 0; n < PIN_N; n++) begin : g_drive
    assign pin_oe_d[n]    = force_out[n] | (~force_in[n] & pin_direction[n]); // R1 R9
    assign pin_value_d[n] = force_out[n] ? force_value[n]
                          : (force_in[n] ? 1'b0 : pin_value[n]); // R2
  end

  // ****************************************************************
  // per-pin read-back
  // ****************************************************************
  // a pin with its direction bit set reads back its data bit, any other the synchronised pin
  for (genvar n = 0; n < PIN_N; n++) begin : g_read
    assign pin_read[n] = pin_direction[n] ? pin_value[n] : pin_sync[n]; // R2
  end

  always_comb begin
    drive_d.value = pin_value_d;
    drive_d.oe    = pin_oe_d;
  end

  // ****************************************************************
  // output register
  // ****************************************************************
  // a write lands in ctrl_q at one edge and on the pins at the next;
  // the extra cycle keeps bus decode glitches off the pin drivers
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      drive_q <= '0; // R8
    end else begin
      drive_q <= drive_d; // R12
    end
  end

  assign PIN_O    = drive_q.value;
  assign PIN_OE_O = drive_q.oe; // R9

  // ****************************************************************
  // read-back word
  // ****************************************************************
  // the word is built field by field, so reserved bits are zero
  always_comb begin
    read_word = '0; // R7
    read_word[TIMER_ROUTE_BIT] = timer_pin_route;
    read_word[BRANCH_ROUTE_BIT] = branch_input_route;
    read_word[FLAG_ROUTE_BIT] = flag_output_route;
    read_word[DIR_LSB +: PIN_N] = pin_direction;
    read_word[CLKSEL_LSB +: 2] = clock_out_select;
    read_word[VALUE_LSB +: PIN_N] = pin_read; // R2
    if (timer_pin_route) begin
      read_word[VALUE_LSB + TIMER_PIN] = ROUTE_I.timer_out; // R3
    end
    if (branch_input_route) begin
      read_word[VALUE_LSB + BRANCH_READ_BIT] = pin_sync[BRANCH_PIN]; // R4
    end
    if (flag_output_route) begin
      read_word[VALUE_LSB + FLAG_READ_BIT] = ROUTE_I.flag_out; // R5
    end
  end

  // ****************************************************************
  // read data register
  // ****************************************************************
  assign rd_hit = RD_I && reg_hit; // R11

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rdata_q <= PIN_CONTROL_RST;
    end else if (rd_hit) begin
      rdata_q <= read_word;
    end
  end

  // read data stands until the next read of this register
  assign RDATA_O = rdata_q;

  // ****************************************************************
  // branch-control input
  // ****************************************************************
  always_comb begin
    branch_d = 1'b0;
    if (branch_input_route) begin
      branch_d = pin_sync[BRANCH_PIN]; // R4
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      branch_q <= 1'b0;
    end else begin
      branch_q <= branch_d;
    end
  end

  assign BRANCH_CONTROL_INPUT_O = branch_q;

  // ****************************************************************
  // clock-out select
  // ****************************************************************
  always_comb begin
    case (clock_out_select)
      2'b00: begin
        clk_sel_d = CLK_SEL_A; // R6
      end
      2'b01: begin
        clk_sel_d = CLK_SEL_B;
      end
      2'b10: begin
        clk_sel_d = CLK_SEL_C;
      end
      2'b11: begin
        clk_sel_d = CLK_SEL_D;
      end
      default: begin
        clk_sel_d = CLK_SEL_A;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      clk_sel_q <= CLK_SEL_A; // R8
    end else begin
      clk_sel_q <= clk_sel_d;
    end
  end

  // the clocks pass through gates, not flops; changing the select
  // while both clocks run can leave a short pulse on the output
  assign clk_pick    = SUBSYS_CLK_I & clk_sel_q;
  assign CLOCK_OUT_O = |clk_pick; // R6
endmodule

// [inc/gpio_ctrl_pkg.sv]
// Operation
// [R1] four pins per core; bits 11..8 set direction, 1 output, 0 input
// [R2] output pins drive their data bit; input pins read back the synchronised level
// [R3] bit 15 drives the timer output on pin 3 and reads it back in data bit 3
// [R4] bit 13 connects pin 1 to branch input, level reads back in data bit 0
// [R5] bit 12 drives external flag on pin 0, level reads back in data bit 1
// [R6] bits 7..6 pick subsystem clock A, B, C or D for clock out
// [R7] bits 14 and 5..4 read zero and ignore writes
// [R8] core reset clears the whole register, so all pins are inputs; the code still drives pin 2 while the watchdog route input is high
// [R9] each pin has its own output enable
// [R10] watchdog route input replaces pin 2 with the watchdog timer output
// [R11] one 16-bit register at offset 3Ch, non-reserved bits read and write
// [R12] writes act on the next edge (PIN_O and PIN_OE_O follow one edge later, through drive_q); pin inputs pass two flip-flops
package gpio_ctrl_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 16;
  localparam int          PIN_N            = 4;
  localparam logic [7:0]  PIN_CONTROL_ADDR = 8'h3C;
  localparam logic [15:0] PIN_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] PIN_CONTROL_WMSK = 16'hBFCF;
  localparam int          TIMER_ROUTE_BIT  = 15;
  localparam int          BRANCH_ROUTE_BIT = 13;
  localparam int          FLAG_ROUTE_BIT   = 12;
  localparam int          DIR_LSB          = 8;
  localparam int          CLKSEL_LSB       = 6;
  localparam int          VALUE_LSB        = 0;
  localparam int          TIMER_PIN        = 3;
  localparam int          WATCHDOG_PIN     = 2;
  localparam int          BRANCH_PIN       = 1;
  localparam int          FLAG_PIN         = 0;
  localparam int          BRANCH_READ_BIT  = 0;
  localparam int          FLAG_READ_BIT    = 1;

  typedef enum logic [3:0] {
    CLK_SEL_A = 4'b0001,
    CLK_SEL_B = 4'b0010,
    CLK_SEL_C = 4'b0100,
    CLK_SEL_D = 4'b1000
  } clk_sel_e;

  typedef struct packed {
    logic [PIN_N-1:0] value;
    logic [PIN_N-1:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic timer_out;
    logic flag_out;
    logic watchdog_out;
    logic watchdog_route;
  } route_src_s;
endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i; // R12
      sync_o <= meta_q;
    end
  end
endmodule

// [verification/subsystem_gpio_control_properties.sv]
`timescale 1ns/1ns
// ***
// pin drive and clock out after a register write, and enables after reset
// ***
module gpio_ctrl_checker
  import gpio_ctrl_pkg::*;
(
  input wire logic                    CLOCK_I,
  input wire logic                    RSTN_I,
  input wire logic [ADDR_W-1:0]       ADDR_I,
  input wire logic                    WR_I,
  input wire logic [DATA_W-1:0]       WDATA_I,
  input wire logic [PIN_N-1:0]        PIN_O,
  input wire logic [PIN_N-1:0]        PIN_OE_O,
  input wire gpio_ctrl_pkg::route_src_s ROUTE_I,
  input wire logic [3:0]              SUBSYS_CLK_I,
  input wire logic                    CLOCK_OUT_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  wire w = WR_I && ADDR_I == PIN_CONTROL_ADDR;
  // the write is stored at one edge and reaches the pins at the next
  property p_oe3;
    w |-> ##2 PIN_OE_O[3] == ($past(WDATA_I[15], 2) | $past(WDATA_I[11], 2));
  endproperty
  a_oe3: assert property (p_oe3) else $error("pin 3 enable");
  property p_oe0;
    w |-> ##2 PIN_OE_O[0] == ($past(WDATA_I[12], 2) | $past(WDATA_I[8], 2));
  endproperty
  a_oe0: assert property (p_oe0) else $error("pin 0 enable");
  property p_oe2;
    w |-> ##2 PIN_OE_O[2] == ($past(ROUTE_I.watchdog_route) | $past(WDATA_I[10], 2));
  endproperty
  a_oe2: assert property (p_oe2) else $error("pin 2 enable");
  property p_tm;
    w && WDATA_I[15] |-> ##2 PIN_O[3] == $past(ROUTE_I.timer_out);
  endproperty
  a_tm: assert property (p_tm) else $error("timer on pin 3");
  property p_fl;
    w && WDATA_I[12] |-> ##2 PIN_O[0] == $past(ROUTE_I.flag_out);
  endproperty
  a_fl: assert property (p_fl) else $error("flag on pin 0");
  property p_v2;
    w && WDATA_I[10] |-> ##2 ($past(ROUTE_I.watchdog_route) || PIN_O[2] == $past(WDATA_I[2], 2));
  endproperty
  a_v2: assert property (p_v2) else $error("pin 2 value");
  property p_ck;
    w |-> ##2 CLOCK_OUT_O == SUBSYS_CLK_I[$past(WDATA_I[7:6], 2)];
  endproperty
  a_ck: assert property (p_ck) else $error("clock out select");
  property p_br;
    w && WDATA_I[13] |-> ##2 !PIN_OE_O[1];
  endproperty
  a_br: assert property (p_br) else $error("branch pin released");
  property p_rs;
    @(posedge CLOCK_I) disable iff (1'b0) !RSTN_I && !ROUTE_I.watchdog_route |=> PIN_OE_O == 4'h0;
  endproperty
  a_rs: assert property (p_rs) else $error("enables after reset");
endmodule
bind subsystem_gpio_control gpio_ctrl_checker u_chk (.*);

// [verification/board_pins.sv]
`timescale 1ns/1ns
// ***
// board side of the pins
// ***
module board_pins (
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] lvl_o
);
  // board only drives released pins, so the wire never has two drivers
  assign lvl_o = (pin_i & oe_i) | (ext_i & ~oe_i);
endmodule

// [verification/subsystem_gpio_control_tb_top.sv]
`timescale 1ns/1ns
module subsystem_gpio_control_tb_top;
  import gpio_ctrl_pkg::*;
  logic             clk = 0, rst_n = 0, wr = 0, rd = 0, bro, cko;
  logic [7:0]       addr = '0;
  logic [15:0]      wd = '0, rdat, rv, w;
  logic [3:0]       ext = '0, po, oe, lvl, sclk = '0, lv;
  route_src_s       route = '0;
  int               bad_count = 0, checks_done = 0, cyc = 0;
  subsystem_gpio_control DUT (.CLOCK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WR_I(wr),
    .RD_I(rd), .WDATA_I(wd), .RDATA_O(rdat), .PIN_I(lvl), .PIN_O(po), .PIN_OE_O(oe),
    .ROUTE_I(route), .BRANCH_CONTROL_INPUT_O(bro), .SUBSYS_CLK_I(sclk), .CLOCK_OUT_O(cko));
  board_pins u_board (.pin_i(po), .oe_i(oe), .ext_i(ext), .lvl_o(lvl));
  initial forever #50 clk = ~clk;
  // ***
  // bus cycles and checks
  // ***
  task automatic bus(logic [7:0] a, logic [15:0] v, logic we);
    addr = a;
    wd = v;
    wr = we;
    rd = !we;
    @(negedge clk);
    rv = rdat;
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask
  task automatic compare(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_oe(logic [15:0] v, route_src_s r);
    logic [3:0] o;
    o = v[11:8];
    if (v[15]) o[3] = 1'b1;
    if (r.watchdog_route) o[2] = 1'b1;
    if (v[13]) o[1] = 1'b0;
    if (v[12]) o[0] = 1'b1;
    return o;
  endfunction
  function automatic logic [3:0] exp_lvl(logic [15:0] v, logic [3:0] x, route_src_s r);
    logic [3:0] o;
    logic [3:0] d;
    o = exp_oe(v, r);
    d = v[3:0];
    if (v[15]) d[3] = r.timer_out;
    if (r.watchdog_route) d[2] = r.watchdog_out;
    if (v[12]) d[0] = r.flag_out;
    return (d & o) | (x & ~o);
  endfunction
  function automatic logic [15:0] expect_rd(logic [15:0] v, logic [3:0] x, route_src_s r);
    logic [15:0] e;
    logic [3:0]  l;
    l = exp_lvl(v, x, r);
    e = v & 16'hBFCF;
    e[3:0] = (v[11:8] & v[3:0]) | (~v[11:8] & l);
    if (v[15]) e[3] = r.timer_out;
    if (v[13]) e[0] = l[1];
    if (v[12]) e[1] = r.flag_out;
    return e;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h4eb0_2b85));
    repeat (2) @(negedge clk);
    rst_n = 1;
    bus(PIN_CONTROL_ADDR, 16'h0000, 0);
    compare(rv, 16'h0000);
    for (int i = 0; i < 60; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hCFFF : (i == 2) ? 16'h30C5 : 16'($urandom());
      ext = 4'($urandom());
      sclk = 4'($urandom());
      route = 4'($urandom());
      bus(PIN_CONTROL_ADDR, w, 1);
      bus(8'h3D, ~w, 1);
      repeat (3) @(negedge clk);
      bus(PIN_CONTROL_ADDR, 16'h0000, 0);
      compare(rv, expect_rd(w, ext, route));
      lv = exp_lvl(w, ext, route);
      compare({12'h000, oe}, {12'h000, exp_oe(w, route)});
      compare({15'h0000, bro}, {15'h0000, w[13] & lv[1]});
      compare({15'h0000, cko}, {15'h0000, sclk[w[7:6]]});
      route = 4'($urandom());
      bus(PIN_CONTROL_ADDR, 16'($urandom()), 1);
      $display("test %0d done", i);
    end
    conclude();
  end
endmodule
